/* File: pkg/uep0_pkg.sv */
// Package of constants and types for the endpoint-0 OUT and address register block
// What this block does
// - Stall bit forces STALL, self-clears on setup
// - Hold 7-bit address, respond only there
// - Status bits set only by hardware events
// - Write one clears status bit, zero ignored
// - Status raises interrupt only when mask set
// - Transaction-complete interrupt gated by enable bit
// - Buffer manager serves endpoint only when enabled
package uep0_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] UEP0_ADDR_OUT_CONFIG = 8'h00;
  localparam logic [7:0] UEP0_ADDR_OUT_COUNT = 8'h04;
  localparam logic [7:0] UEP0_ADDR_FUNC_ADDR = 8'h08;
  localparam logic [7:0] UEP0_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] UEP0_ADDR_MASK = 8'h10;
  // Field positions
  localparam int UEP0_BIT_IRQ_EN = 2;
  localparam int UEP0_BIT_STALL = 3;
  localparam int UEP0_BIT_TOGGLE = 5;
  localparam int UEP0_BIT_BM_EN = 7;
  localparam int UEP0_BIT_NAK = 7;
  localparam int UEP0_CNT_W = 4;
  localparam int UEP0_ADR_W = 7;
  // Status bit positions
  localparam int UEP0_ST_STPOW = 0;
  localparam int UEP0_ST_SETUP = 2;
  localparam int UEP0_ST_XFER = 3;
  localparam int UEP0_ST_RESR = 5;
  localparam int UEP0_ST_SUSR = 6;
  localparam int UEP0_ST_RSTR = 7;
  localparam logic [7:0] UEP0_ST_IMPL = 8'hed;
  // Reset values
  localparam logic [7:0] UEP0_RST_CONFIG = 8'h00;
  localparam logic [7:0] UEP0_RST_COUNT = 8'h80;
  localparam logic [7:0] UEP0_RST_ADDR = 8'h00;
  localparam logic [7:0] UEP0_RST_STATUS = 8'h00;
  localparam logic [7:0] UEP0_RST_MASK = 8'h00;
  localparam logic [3:0] UEP0_MAX_BYTES = 4'h8;

  typedef enum logic [1:0] {
    UEP0_HS_NONE = 2'b00,
    UEP0_HS_ACK = 2'b01,
    UEP0_HS_NAK = 2'b10,
    UEP0_HS_STALL = 2'b11
  } uep0_hs_e;

  // Token seen by the serial engine, one-cycle strobes
  typedef struct packed {
    logic out_tok;
    logic setup_tok;
    logic [6:0] addr;
    logic [3:0] endp;
    logic data_pid1;
    logic [3:0] bytes;
    logic crc_ok;
  } uep0_tok_s;

  typedef struct packed {
    logic valid;
    uep0_hs_e hs;
  } uep0_resp_s;
endpackage

/* File: rtl/uep0_status.sv */
// Sticky event status with write-one-to-clear and masked interrupt
`timescale 1ns/1ps
module uep0_status #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] clr_w1c,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] status,
  output logic irq
);
  initial begin
    if (W < 1) $error("uep0_status width must be positive");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          status[i] <= 1'b0;
        end else if (set_evt[i]) begin
          status[i] <= 1'b1;
        end else if (clr_w1c[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Set wins over clear so no event is lost
  assign irq = |(status & mask);
endmodule

/* File: rtl/uep0_regs.sv */
// Endpoint-0 OUT configuration, byte count, function address and status over APB
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module uep0_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uep0_pkg::uep0_tok_s tok,
  input wire logic ev_resume,
  input wire logic ev_suspend,
  input wire logic ev_bus_reset,
  output uep0_pkg::uep0_resp_s resp,
  output logic bm_service_en,
  output logic data_toggle_flag,
  output logic irq
);
  logic [7:0] ep0_out_config;
  logic [7:0] ep0_out_count;
  logic [6:0] assigned_address_field;
  logic [7:0] bus_event_mask;
  logic [7:0] bus_event_status;
  logic [7:0] set_evt;
  logic [7:0] clr_w1c;
  logic wr;
  logic rd;
  logic mapped;
  logic for_us;
  logic out_hit;
  logic setup_hit;
  logic out_ok;
  logic nak_out;
  logic [3:0] clamped;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == uep0_pkg::UEP0_ADDR_OUT_CONFIG) ||
                  (paddr == uep0_pkg::UEP0_ADDR_OUT_COUNT) ||
                  (paddr == uep0_pkg::UEP0_ADDR_FUNC_ADDR) ||
                  (paddr == uep0_pkg::UEP0_ADDR_STATUS) ||
                  (paddr == uep0_pkg::UEP0_ADDR_MASK);
  assign pslverr = psel && penable && !mapped;

  // Token decode against our own address only
  assign for_us = (tok.addr == assigned_address_field) && (tok.endp == 4'h0);
  assign out_hit = tok.out_tok && for_us && tok.crc_ok;
  assign setup_hit = tok.setup_tok && for_us && tok.crc_ok;
  // Pending setup also blocks OUT, as does the NAK flag
  assign nak_out = ep0_out_count[uep0_pkg::UEP0_BIT_NAK] ||
                   bus_event_status[uep0_pkg::UEP0_ST_SETUP];
  assign out_ok = out_hit && !ep0_out_config[uep0_pkg::UEP0_BIT_STALL] && !nak_out &&
                  (tok.data_pid1 == ep0_out_config[uep0_pkg::UEP0_BIT_TOGGLE]);
  assign clamped = (tok.bytes > uep0_pkg::UEP0_MAX_BYTES) ? uep0_pkg::UEP0_MAX_BYTES :
                   tok.bytes;

  // Handshake answer, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resp <= '{valid: 1'b0, hs: uep0_pkg::UEP0_HS_NONE};
    end else if (setup_hit) begin
      resp <= '{valid: 1'b1, hs: uep0_pkg::UEP0_HS_ACK};
    end else if (out_hit) begin
      if (ep0_out_config[uep0_pkg::UEP0_BIT_STALL]) begin
        resp <= '{valid: 1'b1, hs: uep0_pkg::UEP0_HS_STALL};
      end else if (nak_out) begin
        resp <= '{valid: 1'b1, hs: uep0_pkg::UEP0_HS_NAK};
      end else begin
        // Wrong toggle is a repeat: ack but drop data
        resp <= '{valid: 1'b1, hs: uep0_pkg::UEP0_HS_ACK};
      end
    end else begin
      resp <= '{valid: 1'b0, hs: uep0_pkg::UEP0_HS_NONE};
    end
  end

  // Configuration register; stall and toggle also moved by hardware
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ep0_out_config <= uep0_pkg::UEP0_RST_CONFIG;
    end else begin
      if (wr && paddr == uep0_pkg::UEP0_ADDR_OUT_CONFIG) begin
        ep0_out_config[uep0_pkg::UEP0_BIT_BM_EN] <= pwdata[uep0_pkg::UEP0_BIT_BM_EN];
        ep0_out_config[uep0_pkg::UEP0_BIT_STALL] <= pwdata[uep0_pkg::UEP0_BIT_STALL];
        ep0_out_config[uep0_pkg::UEP0_BIT_IRQ_EN] <= pwdata[uep0_pkg::UEP0_BIT_IRQ_EN];
      end
      // Hardware clear after the software write wins
      if (setup_hit) begin
        ep0_out_config[uep0_pkg::UEP0_BIT_STALL] <= 1'b0;
        ep0_out_config[uep0_pkg::UEP0_BIT_TOGGLE] <= 1'b1;
      end else if (out_ok) begin
        ep0_out_config[uep0_pkg::UEP0_BIT_TOGGLE] <= ~ep0_out_config[uep0_pkg::UEP0_BIT_TOGGLE];
      end
    end
  end

  // Byte count and NAK flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ep0_out_count <= uep0_pkg::UEP0_RST_COUNT;
    end else if (out_ok) begin
      ep0_out_count <= {1'b1, 3'b000, clamped};
    end else if (wr && paddr == uep0_pkg::UEP0_ADDR_OUT_COUNT) begin
      ep0_out_count <= {pwdata[7], 3'b000, pwdata[3:0]};
    end
  end

  // Address loaded by software only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      assigned_address_field <= uep0_pkg::UEP0_RST_ADDR[6:0];
    end else if (wr && paddr == uep0_pkg::UEP0_ADDR_FUNC_ADDR) begin
      assigned_address_field <= pwdata[6:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_event_mask <= uep0_pkg::UEP0_RST_MASK;
    end else if (wr && paddr == uep0_pkg::UEP0_ADDR_MASK) begin
      bus_event_mask <= pwdata[7:0] & uep0_pkg::UEP0_ST_IMPL;
    end
  end

  // Events; overwrite means a setup arrived while one was pending
  always_comb begin
    set_evt = 8'h00;
    set_evt[uep0_pkg::UEP0_ST_SETUP] = setup_hit;
    set_evt[uep0_pkg::UEP0_ST_STPOW] = setup_hit && bus_event_status[uep0_pkg::UEP0_ST_SETUP];
    set_evt[uep0_pkg::UEP0_ST_XFER] = out_ok && ep0_out_config[uep0_pkg::UEP0_BIT_IRQ_EN];
    set_evt[uep0_pkg::UEP0_ST_RESR] = ev_resume;
    set_evt[uep0_pkg::UEP0_ST_SUSR] = ev_suspend;
    set_evt[uep0_pkg::UEP0_ST_RSTR] = ev_bus_reset;
  end
  assign clr_w1c = (wr && paddr == uep0_pkg::UEP0_ADDR_STATUS) ? pwdata[7:0] : 8'h00;

  uep0_status #(.W(8)) u_status (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_evt(set_evt),
    .clr_w1c(clr_w1c),
    .mask(bus_event_mask),
    .status(bus_event_status),
    .irq(irq)
  );

  assign bm_service_en = ep0_out_config[uep0_pkg::UEP0_BIT_BM_EN];
  assign data_toggle_flag = ep0_out_config[uep0_pkg::UEP0_BIT_TOGGLE];

  // Read data registered in the access cycle is not needed; zero-wait combinational mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        uep0_pkg::UEP0_ADDR_OUT_CONFIG: prdata = {24'h00_0000, ep0_out_config & 8'hac};
        uep0_pkg::UEP0_ADDR_OUT_COUNT: prdata = {24'h00_0000, ep0_out_count};
        uep0_pkg::UEP0_ADDR_FUNC_ADDR: prdata = {25'h000_0000, assigned_address_field};
        uep0_pkg::UEP0_ADDR_STATUS: prdata = {24'h00_0000, bus_event_status};
        uep0_pkg::UEP0_ADDR_MASK: prdata = {24'h00_0000, bus_event_mask};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

/* File: tb/uep0_regs_props.sv */
// Port assertions for the endpoint-0 register block
`timescale 1ns/1ps
module uep0_regs_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire uep0_pkg::uep0_tok_s tok,
  input wire logic ev_resume,
  input wire logic ev_suspend,
  input wire logic ev_bus_reset,
  input wire uep0_pkg::uep0_resp_s resp,
  input wire logic bm_service_en,
  input wire logic data_toggle_flag,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = psel & penable & pready;
  wire logic sta = acc & (paddr == uep0_pkg::UEP0_ADDR_STATUS);
  wire logic msk = acc & pwrite & (paddr == uep0_pkg::UEP0_ADDR_MASK);
  wire logic cnt = acc & ~pwrite & (paddr == uep0_pkg::UEP0_ADDR_OUT_COUNT);
  // Any pending set event may win over the clear
  wire logic quiet = ~(ev_resume | ev_suspend | ev_bus_reset | tok.out_tok | tok.setup_tok);
  sequence s_setup_ack; tok.setup_tok ##1 resp.valid; endsequence
  sequence s_cfg_wr; acc && pwrite && paddr == uep0_pkg::UEP0_ADDR_OUT_CONFIG; endsequence
  a_setup_acks: assert property (s_setup_ack |-> resp.hs == uep0_pkg::UEP0_HS_ACK)
    else $error("setup token not acked");
  a_setup_toggle: assert property (s_setup_ack |-> data_toggle_flag)
    else $error("toggle not set by setup");
  a_resp_own_ep: assert property (resp.valid |-> $past(tok.crc_ok) && $past(tok.endp) == 4'h0)
    else $error("answer to foreign token");
  a_status_rsv: assert property (sta && !pwrite |-> !prdata[1] && !prdata[4])
    else $error("unused status bit set");
  a_clear_all: assert property (sta && pwrite && pwdata[7:0] == 8'hff && quiet |=> !irq)
    else $error("status not cleared");
  a_mask_off: assert property (msk && pwdata[7:0] == 8'h00 |=> !irq)
    else $error("irq with all masked");
  a_bm_enable: assert property (s_cfg_wr |=> bm_service_en == $past(pwdata[7]))
    else $error("service enable not loaded");
  a_count_range: assert property (cnt |-> prdata[6:4] == 3'h0 && prdata[3:0] <= 4'h8)
    else $error("byte count out of range");
endmodule
bind uep0_regs uep0_regs_props u_props (.*);

/* File: tb/uep0_host.sv */
// Host model presenting one-cycle token strobes
`timescale 1ns/1ps
module uep0_host (
  input wire logic ref_clk,
  input wire logic go,
  input wire uep0_pkg::uep0_tok_s cmd,
  output uep0_pkg::uep0_tok_s tok = '0
);
  // Idle fields flip each cycle so stale values never look valid
  always @(posedge ref_clk) tok <= go ? cmd : {2'b00, ~tok[16:0]};
endmodule

/* File: tb/uep0_regs_tb_top.sv */
// Self-checking bench for the endpoint-0 register block
`timescale 1ns/1ps
module uep0_regs_tb_top;
  localparam logic [7:0] CFG = uep0_pkg::UEP0_ADDR_OUT_CONFIG;
  localparam logic [7:0] CNT = uep0_pkg::UEP0_ADDR_OUT_COUNT;
  localparam logic [7:0] STA = uep0_pkg::UEP0_ADDR_STATUS;
  localparam logic [1:0] ACK = uep0_pkg::UEP0_HS_ACK, NAK = uep0_pkg::UEP0_HS_NAK;
  logic ref_clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, go = '0;
  logic pready, irq, bm, tog;
  logic [7:0] msk = '0;
  logic [7:0] paddr = '0, hs_q[$], rd_q[$];
  logic [31:0] pwdata = '0, prdata, lfsr = 32'hfc52313b;
  logic [2:0] ev = '0;
  logic [6:0] fa;
  int fail_count = 0, checked = 0, n;
  uep0_pkg::uep0_tok_s cmd = '0, tok;
  uep0_pkg::uep0_resp_s resp;
  always #2 ref_clk = ~ref_clk;
  uep0_host host (.ref_clk(ref_clk), .go(go), .cmd(cmd), .tok(tok));
  uep0_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .tok(tok), .ev_resume(ev[0]), .ev_suspend(ev[1]), .ev_bus_reset(ev[2]),
    .resp(resp), .bm_service_en(bm), .data_toggle_flag(tog), .irq(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    // Unanswered expectations count as misses
    if (hs_q.size() != 0 || rd_q.size() != 0) fail_count++;
    $display("checked %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (w && a == uep0_pkg::UEP0_ADDR_MASK) msk = d;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk) penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this step
    @(posedge ref_clk);
    if (n == 8) fail_count++;
    if (n == 8) complete_run;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  // Code 4 means no answer is expected
  task automatic tk(input logic o, input logic [6:0] a, input logic p, input logic [3:0] b,
    input logic [2:0] h);
    if (!h[2]) hs_q.push_back({6'h0, h[1:0]});
    go <= 1'b1;
    cmd <= {o, ~o, a, 4'h0, p, b, 1'b1};
    @(posedge ref_clk) go <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (resp.valid === 1'b1) chk({6'h0, resp.hs}, hs_q.pop_front());
    if (psel && penable && !pwrite && pready) begin
      if (paddr == STA) chk({7'h0, irq}, {7'h0, |(rd_q[0] & msk)});
      if (paddr == CFG) chk({bm, 1'b0, tog, 5'h0}, rd_q[0] & 8'ha0);
      chk(prdata[7:0], rd_q.pop_front());
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), i == 1 ? 8'h80 : 8'h00);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    fa = lfsr[6:0];
    apb(1'b1, uep0_pkg::UEP0_ADDR_FUNC_ADDR, {1'b0, fa});
    tk(1'b1, ~fa, 1'b0, 4'h1, 3'h4);
    tk(1'b1, fa, 1'b0, 4'h1, NAK);
    $display("test reset and address done");
    apb(1'b1, CNT, 8'h00);
    apb(1'b1, CFG, 8'h04);
    apb(1'b1, uep0_pkg::UEP0_ADDR_MASK, 8'h08);
    tk(1'b1, fa, 1'b1, 4'h3, ACK);
    tk(1'b1, fa, 1'b0, 4'hc, ACK);
    rd(CNT, 8'h88);
    rd(CFG, 8'h24);
    rd(STA, 8'h08);
    $display("test out data done");
    apb(1'b1, STA, 8'hf7);
    rd(STA, 8'h08);
    ev <= 3'h7;
    @(posedge ref_clk) ev <= 3'h0;
    rd(STA, 8'he8);
    apb(1'b1, STA, 8'hff);
    rd(STA, 8'h00);
    $display("test status done");
    apb(1'b1, CFG, 8'h8c);
    tk(1'b1, fa, 1'b0, 4'h1, uep0_pkg::UEP0_HS_STALL);
    tk(1'b0, fa, 1'b0, 4'h8, ACK);
    rd(CFG, 8'ha4);
    tk(1'b0, fa, 1'b0, 4'h8, ACK);
    rd(STA, 8'h05);
    apb(1'b1, CNT, 8'h00);
    tk(1'b1, fa, 1'b1, 4'h1, NAK);
    apb(1'b1, uep0_pkg::UEP0_ADDR_MASK, 8'h04);
    rd(STA, 8'h05);
    apb(1'b1, uep0_pkg::UEP0_ADDR_MASK, 8'h00);
    rd(STA, 8'h05);
    $display("test stall and setup done");
    complete_run;
  end
endmodule
